/* bench/gpi_haptic_playback_sequencer_tb.sv */
// self-checking bench: host end and device end joined by the link
// assumes 125 MHz ref_clk; full effect lengths are too long to run here
`timescale 1ns/1ps
`default_nettype none
module gpi_haptic_playback_sequencer_tb
   import hps_pkg::*;
   ;
   logic             ref_clk = 1'b0;
   logic             reset_n = 1'b0;
   logic             enable_req = 1'b0;
   logic [2:0]       pulse_req = 3'h0;
   logic [3:0]       flt = 4'h0;
   logic [AMP_W-1:0] supply_level = 8'hff;
   logic             busy, drive_on, brake_on, cal_valid, seq_done;
   logic             fault_abort;
   logic [3:0]       state_out;
   logic [2:0]       effect_out;
   logic [AMP_W-1:0] drive_amp;
   int errors = 0, total_checks = 0, seed = 88;
   int n_done = 0, n_abort = 0, m_state = 0, d = 0;
   // model: effects expected for the playbacks started so far
   int fx_q[$];

   hps_link_if link ();
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (seq_done === 1'b1) n_done++;
      if (fault_abort === 1'b1) n_abort++;
   end

   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   hps_host hps_host_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .link(link.host), .enable_req(enable_req), .pulse_req(pulse_req),
      .busy(busy));
   hps_device hps_device_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .link(link.device), .supply_undervoltage_lockout(flt[0]),
      .over_temp(flt[1]), .short_circuit(flt[2]),
      .impedance_fault(flt[3]), .supply_level(supply_level),
      .state_out(state_out), .effect_out(effect_out), .drive_on(drive_on),
      .brake_on(brake_on), .drive_amp(drive_amp), .cal_valid(cal_valid),
      .seq_done(seq_done), .fault_abort(fault_abort));
   hps_link_asserts hps_link_asserts_inst (.ref_clk(ref_clk),
      .reset_n(reset_n), .click_trigger_in(link.click_trigger_in),
      .strong_buzz_trigger_in(link.strong_buzz_trigger_in),
      .medium_buzz_trigger_in(link.medium_buzz_trigger_in),
      .io_supply_enable(link.io_supply_enable),
      .supply_undervoltage_lockout(flt[0]), .over_temp(flt[1]),
      .short_circuit(flt[2]), .impedance_fault(flt[3]),
      .state_out(state_out), .drive_on(drive_on), .brake_on(brake_on),
      .drive_amp(drive_amp), .cal_valid(cal_valid), .seq_done(seq_done),
      .fault_abort(fault_abort));

   // ------------------------------------------------------------
   // tasks and model
   // ------------------------------------------------------------
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // the host ignores requests while busy, so wait it out first
   task automatic trig(int i);
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 4000) begin
         cyc(1);
         k++;
      end
      check("busy", busy, 0);
      pulse_req[i] = 1'b1;
      cyc(1);
      pulse_req = 3'h0;
      cyc(10);
      m_state = (m_state == ST_IDLE) ? ST_DRIVE : ST_IDLE;
      if (m_state == ST_DRIVE) begin
         fx_q.push_back(1 << i);
      end
   endtask : trig
   function automatic logic [AMP_W-1:0] amp_exp(int i);
      logic [AMP_W-1:0] lvl, cap;
      lvl = (i == 2) ? AMP_MEDIUM : AMP_HIGH;
      cap = supply_level - SUPPLY_HEADROOM;
      return (lvl < cap) ? lvl : cap;
   endfunction : amp_exp

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      // twelve host pulses of about 3.1k cycles each; 60k cycles is ample
      #480_000;
      errors++;
      report_and_stop();
   end
   initial begin
      cyc(3);
      reset_n = 1'b1;
      check("state", state_out, ST_OFF);
      enable_req = 1'b1;
      cyc(3);
      check("state", state_out, ST_BOOT);
      cyc(16);
      m_state = ST_IDLE;
      check("state", state_out, m_state);
      $display("test boot done");
      for (int i = 0; i < 3; i++) begin
         supply_level = 8'h80 | 8'($random(seed));
         trig(i);
         check("state", state_out, m_state);
         d = fx_q.pop_front();
         check("fx", effect_out, d);
         check("drive_on", drive_on, 1);
         check("brake", brake_on, 0);
         check("amp", drive_amp, amp_exp(i));
         d = n_done;
         trig((i + 1) % 3);
         check("state", state_out, m_state);
         check("done", n_done, d + 1);
         check("amp", drive_amp, 0);
         check("drive_on", drive_on, 0);
      end
      $display("test effects done");
      for (int i = 0; i < 4; i++) begin
         trig(1);
         check("state", state_out, m_state);
         check("fx", effect_out, fx_q.pop_front());
         d = n_abort;
         flt[i] = 1'b1;
         cyc(3);
         flt = 4'h0;
         cyc(2);
         m_state = ST_IDLE;
         check("state", state_out, m_state);
         check("abort", n_abort, d + 1);
      end
      d = n_abort;
      flt = 4'hf;
      cyc(4);
      flt = 4'h0;
      check("state", state_out, ST_IDLE);
      check("abort", n_abort, d);
      $display("test faults done");
      enable_req = 1'b0;
      cyc(4);
      check("state", state_out, ST_OFF);
      check("cal", cal_valid, 0);
      enable_req = 1'b1;
      cyc(22);
      check("state", state_out, ST_IDLE);
      trig(2);
      check("state", state_out, m_state);
      check("fx", effect_out, fx_q.pop_front());
      check("amp", drive_amp, amp_exp(2));
      trig(2);
      check("state", state_out, m_state);
      $display("test re-enable done");
      report_and_stop();
   end
endmodule : gpi_haptic_playback_sequencer_tb
`default_nettype wire

/* bench/hps_link_asserts.sv */
// checker for the haptic sequencer link and the device end's outputs
// assumes it is instantiated beside the link interface in the bench top
`timescale 1ns/1ps
`default_nettype none
module hps_link_asserts
   import hps_pkg::*;
(
   input wire logic             ref_clk,
   input wire logic             reset_n,
   input wire logic             click_trigger_in,
   input wire logic             strong_buzz_trigger_in,
   input wire logic             medium_buzz_trigger_in,
   input wire logic             io_supply_enable,
   input wire logic             supply_undervoltage_lockout,
   input wire logic             over_temp,
   input wire logic             short_circuit,
   input wire logic             impedance_fault,
   input wire logic [3:0]       state_out,
   input wire logic             drive_on,
   input wire logic             brake_on,
   input wire logic [AMP_W-1:0] drive_amp,
   input wire logic             cal_valid,
   input wire logic             seq_done,
   input wire logic             fault_abort
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   wire logic [2:0] pins = {medium_buzz_trigger_in, strong_buzz_trigger_in,
                            click_trigger_in};
   wire logic       flt = supply_undervoltage_lockout | over_temp |
                          short_circuit | impedance_fault;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_off_when_low: assert property (
      !io_supply_enable |=> state_out == ST_OFF)
      else $error("device not off while disabled");
   a_boot_first: assert property (
      state_out == ST_OFF && io_supply_enable |=> state_out == ST_BOOT)
      else $error("enable did not start boot");
   // boot may be cut short by the enable, so that case is left out
   a_boot_to_idle: assert property (
      @(posedge ref_clk) disable iff (!reset_n || !io_supply_enable)
      $rose(state_out == ST_BOOT) |-> ##[15:17] state_out == ST_IDLE)
      else $error("boot did not settle in idle");
   a_drive_from_idle: assert property (
      $rose(state_out == ST_DRIVE) |->
         $past(state_out) == ST_IDLE && !(&$past(pins, 2)))
      else $error("drive entered without idle and trigger");
   a_fault_aborts: assert property (
      state_out == ST_DRIVE && flt |->
         ##[1:2] fault_abort ##[0:1] state_out == ST_IDLE)
      else $error("fault did not abort playback");
   a_fault_holds: assert property (
      fault_abort |-> (state_out != ST_DRIVE) [*4])
      else $error("drive resumed after fault");
   a_done_idle: assert property (
      seq_done |-> ##[0:1] state_out == ST_IDLE)
      else $error("sequence end without idle");
   a_stop_only: assert property (
      $fell(state_out == ST_DRIVE) && io_supply_enable |->
         (state_out != ST_DRIVE) [*4])
      else $error("stop edge restarted playback");
   a_brake_drive: assert property (
      brake_on |-> drive_on && state_out == ST_DRIVE)
      else $error("brake outside drive");
   a_amp_idle: assert property (
      state_out == ST_IDLE && $past(state_out) == ST_IDLE |->
         drive_amp == AMP_ZERO)
      else $error("amplitude nonzero in idle");
   a_cal_lost: assert property (
      !io_supply_enable ##1 !io_supply_enable |-> !cal_valid)
      else $error("calibration kept while disabled");
endmodule : hps_link_asserts
`default_nettype wire

/* hw/hps_device.sv */
// device end of the haptic playback sequencer
// assumes trigger pins come from the host over hps_link_if and analog
// fault and supply flags are synchronous to ref_clk
//
// Operation
// - enable high: load boot settings first
// - after boot wait in idle
// - falling trigger edge starts mapped effect
// - sequence end or edge returns to idle
// - any fault aborts playback to idle
// - click: 25 drive, 10 brake, 20 silence
// - strong buzz: high level, max 60 s
// - medium buzz: low level, max 60 s
// - after sequence, idle and accept triggers
// - stop edge never starts a new effect
// - host spaces start/stop edges for length
// - 250 ms calibration run is kept
// - enable low discards calibration
// - play effects even without calibration
// - cap amplitude 1.12 V below supply
// - enable low is off and resets all but div; seq_done/fault_abort can still pulse
// - low-rated actuators: host uses medium only
// - host may chain effects for patterns
// - buzz ends itself after 60 s
// - after fault, wait for next trigger
// - host holds trigger low over 25 us
`timescale 1ns/1ps
`default_nettype none
module hps_device
   import hps_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   hps_link_if.device            link,
   input  wire logic             supply_undervoltage_lockout,
   input  wire logic             over_temp,
   input  wire logic             short_circuit,
   input  wire logic             impedance_fault,
   input  wire logic [AMP_W-1:0] supply_level,
   output logic      [3:0]       state_out,
   output logic      [2:0]       effect_out,
   output logic                  drive_on,
   output logic                  brake_on,
   output logic      [AMP_W-1:0] drive_amp,
   output logic                  cal_valid,
   output logic                  seq_done,
   output logic                  fault_abort
);
   typedef struct packed {
      hps_state_t       state;
      hps_phase_t       phase;
      hps_effect_t      effect;
      logic [4:0]       boot_cnt;
      logic [DIV_W-1:0] div;
      logic [TICK_W-1:0] ticks;
      logic             cal_run;
      logic             cal_valid;
      logic             drive_on;
      logic             brake_on;
      logic [AMP_W-1:0] amp;
      logic             seq_done;
      logic             fault_abort;
   } hps_dev_t;

   hps_dev_t st_r;
   hps_dev_t st_nxt;

   logic [2:0] fall;
   logic       any_fall;
   logic       fault;
   logic       tick;
   logic [AMP_W-1:0] amp_cap;

   hps_fall_det u_fall (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pin_in  ({link.medium_buzz_trigger_in,
                 link.strong_buzz_trigger_in,
                 link.click_trigger_in}),
      .fall    (fall)
   );

   assign any_fall = |fall;
   assign fault    = supply_undervoltage_lockout | over_temp |
                     short_circuit | impedance_fault;
   assign tick     = (st_r.div == DIV_W'(TICK_CYC - 1));
   // headroom cap; a supply below the headroom gives zero drive
   assign amp_cap  = (supply_level > SUPPLY_HEADROOM) ?
                     AMP_W'(supply_level - SUPPLY_HEADROOM) : AMP_ZERO;

   // ------------------------------------------------------------
   // state machine
   // ------------------------------------------------------------
   always_comb begin
      logic [AMP_W-1:0] lvl;
      lvl = AMP_ZERO;
      st_nxt = st_r;
      st_nxt.seq_done    = 1'b0;
      st_nxt.fault_abort = 1'b0;
      st_nxt.div = tick ? '0 : DIV_W'(st_r.div + 1'b1);
      case (st_r.state)
         ST_OFF: begin
            if (link.io_supply_enable) begin
               st_nxt.state    = ST_BOOT;
               st_nxt.boot_cnt = '0;
            end
         end
         ST_BOOT: begin
            st_nxt.boot_cnt = 5'(st_r.boot_cnt + 1'b1);
            if (st_r.boot_cnt == 5'(BOOT_CYC - 1)) begin
               st_nxt.state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // lowest index wins if edges coincide
            if (any_fall) begin
               st_nxt.state    = ST_DRIVE;
               st_nxt.phase    = PH_DRIVE;
               st_nxt.ticks    = '0;
               st_nxt.div      = '0;
               st_nxt.drive_on = 1'b1;
               st_nxt.brake_on = 1'b0;
               st_nxt.cal_run  = 1'b0;
               if (fall[0]) begin
                  st_nxt.effect = FX_CLICK;
               end else if (fall[1]) begin
                  st_nxt.effect = FX_STRONG;
               end else begin
                  st_nxt.effect = FX_MEDIUM;
                  // first medium run after enable calibrates
                  st_nxt.cal_run = ~st_r.cal_valid;
               end
            end
         end
         ST_DRIVE: begin
            if (tick) begin
               st_nxt.ticks = TICK_W'(st_r.ticks + 1'b1);
            end
            if (st_r.cal_run && tick &&
                st_r.ticks == TICK_W'(CAL_TICKS - 1)) begin
               st_nxt.cal_valid = 1'b1;
            end
            if (fault) begin
               st_nxt.state       = ST_IDLE;
               st_nxt.fault_abort = 1'b1;
            end else if (any_fall) begin
               st_nxt.state    = ST_IDLE;
               st_nxt.seq_done = 1'b1;
            end else if (st_r.effect == FX_CLICK) begin
               case (st_r.phase)
                  PH_DRIVE: begin
                     if (tick && st_r.ticks ==
                         TICK_W'(CLICK_DRIVE_TICKS - 1)) begin
                        st_nxt.phase = PH_BRAKE;
                        st_nxt.ticks = '0;
                     end
                  end
                  PH_BRAKE: begin
                     if (tick && st_r.ticks ==
                         TICK_W'(CLICK_BRAKE_TICKS - 1)) begin
                        st_nxt.phase = PH_SILENCE;
                        st_nxt.ticks = '0;
                     end
                  end
                  default: begin
                     if (tick && st_r.ticks ==
                         TICK_W'(CLICK_SILENCE_TICKS - 1)) begin
                        st_nxt.state    = ST_IDLE;
                        st_nxt.seq_done = 1'b1;
                     end
                  end
               endcase
            end else if (tick && st_r.ticks ==
                         TICK_W'(BUZZ_MAX_TICKS - 1)) begin
               st_nxt.state    = ST_IDLE;
               st_nxt.seq_done = 1'b1;
            end
         end
         default: begin
            st_nxt.state = ST_OFF;
         end
      endcase

      // uncalibrated playback still drives at nominal level; the level
      // follows the effect being entered, so a start has no stale cycle
      if (st_nxt.effect == FX_MEDIUM) begin
         lvl = AMP_MEDIUM;
      end else begin
         lvl = AMP_HIGH;
      end
      st_nxt.drive_on = (st_nxt.state == ST_DRIVE) &&
                        (st_nxt.phase != PH_SILENCE);
      st_nxt.brake_on = (st_nxt.state == ST_DRIVE) &&
                        (st_nxt.phase == PH_BRAKE);
      if (st_nxt.drive_on && !st_nxt.brake_on) begin
         st_nxt.amp = (lvl > amp_cap) ? amp_cap : lvl;
      end else begin
         st_nxt.amp = AMP_ZERO;
      end

      // enable low overrides everything except div and the seq_done and fault_abort pulses
      if (!link.io_supply_enable) begin
         st_nxt.state     = ST_OFF;
         st_nxt.effect    = FX_CLICK;
         st_nxt.phase     = PH_DRIVE;
         st_nxt.ticks     = '0;
         st_nxt.boot_cnt  = '0;
         st_nxt.cal_valid = 1'b0;
         st_nxt.cal_run   = 1'b0;
         st_nxt.drive_on  = 1'b0;
         st_nxt.brake_on  = 1'b0;
         st_nxt.amp       = AMP_ZERO;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '{state: ST_OFF, phase: PH_DRIVE, effect: FX_CLICK,
                   boot_cnt: '0, div: '0, ticks: '0, cal_run: 1'b0,
                   cal_valid: 1'b0, drive_on: 1'b0, brake_on: 1'b0,
                   amp: AMP_ZERO, seq_done: 1'b0, fault_abort: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign state_out   = st_r.state;
   assign effect_out  = st_r.effect;
   assign drive_on    = st_r.drive_on;
   assign brake_on    = st_r.brake_on;
   assign drive_amp   = st_r.amp;
   assign cal_valid   = st_r.cal_valid;
   assign seq_done    = st_r.seq_done;
   assign fault_abort = st_r.fault_abort;
endmodule : hps_device
`default_nettype wire

/* hw/hps_fall_det.sv */
// synchroniser and falling-edge detector for the three trigger pins
// assumes pins idle high and are held low > 25 us by the host
`timescale 1ns/1ps
`default_nettype none
module hps_fall_det
   import hps_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [2:0] pin_in,
   output logic      [2:0] fall
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
   } hps_sync_t;

   hps_sync_t st_r;
   hps_sync_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   // reset to high, so a pin held low at start gives one falling edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7};
      end else begin
         st_r <= st_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_fall
         assign fall[g] = st_r.s3[g] & ~st_r.s2[g];
      end
   endgenerate
endmodule : hps_fall_det
`default_nettype wire

/* hw/hps_host.sv */
// host end: turns user requests into enable level and trigger pulses
// assumes user requests are one-cycle pulses on ref_clk
`timescale 1ns/1ps
`default_nettype none
module hps_host
   import hps_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   hps_link_if.host        link,
   input  wire logic       enable_req,
   input  wire logic [2:0] pulse_req,
   output logic            busy
);
   typedef struct packed {
      logic       en;
      logic [2:0] pin;
      logic [12:0] cnt;
      logic       busy;
   } hps_host_t;

   hps_host_t st_r;
   hps_host_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.en = enable_req;
      if (st_r.busy) begin
         // hold low past the minimum pulse width
         st_nxt.cnt = 13'(st_r.cnt + 1'b1);
         if (st_r.cnt == 13'(TRIG_LOW_CYC - 1)) begin
            st_nxt.pin  = 3'h7;
            st_nxt.busy = 1'b0;
         end
      end else if (|pulse_req && enable_req) begin
         // every requested pin goes low together; choose by pin for pattern
         st_nxt.pin  = ~pulse_req;
         st_nxt.cnt  = '0;
         st_nxt.busy = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '{en: 1'b0, pin: 3'h7, cnt: '0, busy: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.io_supply_enable       = st_r.en;
   assign link.click_trigger_in       = st_r.pin[0];
   assign link.strong_buzz_trigger_in = st_r.pin[1];
   assign link.medium_buzz_trigger_in = st_r.pin[2];
   assign busy                        = st_r.busy;
endmodule : hps_host
`default_nettype wire

/* hw/hps_link_if.sv */
// link between host and haptic sequencer: trigger pins and enable
// assumes both ends run on the same ref_clk
`timescale 1ns/1ps
`default_nettype none
interface hps_link_if;
   logic click_trigger_in;
   logic strong_buzz_trigger_in;
   logic medium_buzz_trigger_in;
   logic io_supply_enable;

   modport device (
      input click_trigger_in,
      input strong_buzz_trigger_in,
      input medium_buzz_trigger_in,
      input io_supply_enable
   );

   modport host (
      output click_trigger_in,
      output strong_buzz_trigger_in,
      output medium_buzz_trigger_in,
      output io_supply_enable
   );
endinterface : hps_link_if
`default_nettype wire

/* hw/hps_pkg.sv */
// package for the haptic playback sequencer: states, drive levels, timing
// assumes one 125 MHz clock shared by both ends
package hps_pkg;

   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLICK_DRIVE_MS = 25;
   localparam int unsigned CLICK_BRAKE_MS = 10;
   localparam int unsigned CLICK_SILENCE_MS = 20;
   localparam int unsigned BUZZ_MAX_S = 60;
   localparam int unsigned CAL_MS = 250;
   localparam int unsigned BUZZ_MIN_MS = 5;
   localparam int unsigned TRIG_LOW_US = 25;
   localparam int unsigned BOOT_CYC = 16;
   localparam int unsigned TICK_CYC = CLK_KHZ;

   localparam int unsigned CLICK_DRIVE_TICKS = CLICK_DRIVE_MS;
   localparam int unsigned CLICK_BRAKE_TICKS = CLICK_BRAKE_MS;
   localparam int unsigned CLICK_SILENCE_TICKS = CLICK_SILENCE_MS;
   localparam int unsigned BUZZ_MAX_TICKS = BUZZ_MAX_S * 1000;
   localparam int unsigned CAL_TICKS = CAL_MS;
   localparam int unsigned BUZZ_MIN_TICKS = BUZZ_MIN_MS;
   localparam int unsigned TRIG_LOW_CYC =
      (TRIG_LOW_US * (CLK_HZ / 1_000_000)) + 1;

   localparam int TICK_W = 17;
   localparam int DIV_W = 17;
   localparam int AMP_W = 8;

   // ------------------------------------------------------------
   // drive levels in 10 mV units; headroom below supply
   // ------------------------------------------------------------
   localparam logic [AMP_W-1:0] AMP_HIGH = 8'hb4;
   localparam logic [AMP_W-1:0] AMP_MEDIUM = 8'h64;
   localparam logic [AMP_W-1:0] SUPPLY_HEADROOM = 8'h70;
   localparam logic [AMP_W-1:0] AMP_ZERO = 8'h00;

   typedef enum logic [3:0] {
      ST_OFF   = 4'b0001,
      ST_BOOT  = 4'b0010,
      ST_IDLE  = 4'b0100,
      ST_DRIVE = 4'b1000
   } hps_state_t;

   typedef enum logic [2:0] {
      PH_DRIVE   = 3'b001,
      PH_BRAKE   = 3'b010,
      PH_SILENCE = 3'b100
   } hps_phase_t;

   typedef enum logic [2:0] {
      FX_CLICK  = 3'b001,
      FX_STRONG = 3'b010,
      FX_MEDIUM = 3'b100
   } hps_effect_t;

endpackage : hps_pkg
